/* File: rtl/fvc_bank.v */
`include "fvc_consts.vh"

//
// Behaviour
// - Clear bit inverts line 3 in training.
// - Two-bit field picks CRC chunk 16..128.
// - CRC parity on in octal DDR when 0.
// - Type bit picks detection or correction event.
// - Type choice only applies while ECC on.
// - Error pin only drives when enable 0.
// - Bit 0 low turns ECC on.
// - Training pattern 55h, sent MSB first.
// - Wrap byte picks none, 64, 32, 16.
// - FEh enables execute-in-place, FFh disables.
// - FEh gives four address bytes, FFh three.
// - Drive byte picks 50/35/25/18 ohm.
// - Codes 1..30 set dummy count, 1Fh default.
// - Code 00h acts like 1Fh.
// - Mode byte picks SPI/octal, strobe or not.
// - Octal-boot parts stay octal DDR with strobe.
// - Chunk address of first selected event kept.
module fvc_bank #(
    parameter CHUNK_W = 28
) (
    // Clock, reset, enable
    input  wire               clk_i,
    input  wire               rstn_i,
    input  wire               ce_i,
    // Serial link pins
    input  wire               sck_i,
    input  wire               cs_n_i,
    input  wire [7:0]         dq_i,
    output reg  [7:0]         dq_o,
    output reg                dq_oe_o,
    output reg                dqs_o,
    // Boot strap
    input  wire               boot_octal_i,
    // ECC engine events
    input  wire               ecc_corr_i,
    input  wire               ecc_det_i,
    input  wire [CHUNK_W-1:0] ecc_chunk_i,
    output reg                err_n_o,
    output reg  [CHUNK_W-1:0] ecc_fail_chunk_o,
    output reg                ecc_fail_valid_o,
    // Decoded settings
    output reg                octal_ddr_o,
    output reg                strobe_en_o,
    output reg  [4:0]         dummy_cycles_o,
    output reg                dummy_default_o,
    output reg  [1:0]         drive_sel_o,
    output reg                addr_4byte_o,
    output reg                xip_enable_o,
    output reg  [1:0]         wrap_sel_o,
    output reg  [7:0]         crc_chunk_bytes_o,
    output reg                crc_parity_en_o,
    output reg                ecc_enable_o
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CMD   = 3'h1;
    localparam [2:0] ST_ADDR  = 3'h2;
    localparam [2:0] ST_WR    = 3'h3;
    localparam [2:0] ST_RD    = 3'h4;
    localparam [2:0] ST_TRAIN = 3'h5;
    localparam [2:0] ST_SKIP  = 3'h6;

    wire       sck_rise_w;
    wire       sck_fall_w;
    wire       cs_act_w;
    wire       frame_start_w;
    wire [7:0] dq_s_w;
    wire       strap_s_w;

    reg  [2:0] state_q;
    reg        is_wr_q;
    reg  [7:0] addr_q;
    reg  [2:0] bit_idx_q;
    reg  [1:0] strap_wait_q;
    reg        strap_q;
    reg        err_flag_q;

    reg  [7:0] io_protocol_mode_q;
    reg  [7:0] dummy_cycle_count_q;
    reg  [7:0] output_drive_select_q;
    reg  [7:0] address_width_select_q;
    reg  [7:0] execute_in_place_enable_q;
    reg  [7:0] read_wrap_select_q;
    reg  [7:0] training_pattern_q;
    reg  [7:0] integrity_error_control_q;

    reg  [7:0] rd_byte;
    wire       wr_en;
    wire       ecc_on;
    wire       sel_event;
    wire       switching_pattern_select;
    wire       error_type_select;
    wire       error_pin_enable_n;
    wire       crc_parity_enable_n;
    wire [1:0] crc_chunk_size;

    fvc_link_sync u_sync (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .ce_i          (ce_i),
        .sck_i         (sck_i),
        .cs_n_i        (cs_n_i),
        .dq_i          (dq_i),
        .strap_i       (boot_octal_i),
        .sck_rise_o    (sck_rise_w),
        .sck_fall_o    (sck_fall_w),
        .cs_act_o      (cs_act_w),
        .frame_start_o (frame_start_w),
        .dq_o          (dq_s_w),
        .strap_o       (strap_s_w)
    );

    // Field views of the integrity byte
    assign switching_pattern_select = integrity_error_control_q[`FVC_B_SSO];
    assign crc_chunk_size      = integrity_error_control_q[`FVC_B_CRCSZ_HI:`FVC_B_CRCSZ_LO];
    assign crc_parity_enable_n = integrity_error_control_q[`FVC_B_CRC_EN_N];
    assign error_type_select   = integrity_error_control_q[`FVC_B_ERR_TYPE];
    assign error_pin_enable_n  = integrity_error_control_q[`FVC_B_ERR_PIN_EN_N];
    assign ecc_on              = ~integrity_error_control_q[`FVC_B_ECC_EN_N];

    // Selected event only counts while correction is on
    assign sel_event = ecc_on & (error_type_select ? ecc_det_i : ecc_corr_i);

    // Write strobe: one per rising link edge in the data phase
    assign wr_en = ce_i & cs_act_w & ~frame_start_w & (state_q == ST_WR) & sck_rise_w;

    // Strap caught once; waits until the sync chain holds the pin, not its reset value
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_wait_q <= 2'h0;
            strap_q      <= 1'b0;
        end
        else if (ce_i && strap_wait_q != 2'h3)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == 2'h2)
                strap_q <= strap_s_w;
        end
    end

    // Register file; reserved bytes drop writes
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            io_protocol_mode_q        <= `FVC_RST_IO_MODE;
            dummy_cycle_count_q       <= `FVC_RST_DUMMY;
            output_drive_select_q     <= `FVC_RST_DRIVE;
            address_width_select_q    <= `FVC_RST_ADDR_WIDTH;
            execute_in_place_enable_q <= `FVC_RST_XIP;
            read_wrap_select_q        <= `FVC_RST_WRAP;
            training_pattern_q        <= `FVC_RST_TRAIN;
            integrity_error_control_q <= `FVC_RST_INTEGRITY;
        end
        else if (wr_en)
        begin
            case (addr_q)
                `FVC_OFS_IO_MODE:    io_protocol_mode_q        <= dq_s_w;
                `FVC_OFS_DUMMY:      dummy_cycle_count_q       <= dq_s_w;
                `FVC_OFS_DRIVE:      output_drive_select_q     <= dq_s_w;
                `FVC_OFS_ADDR_WIDTH: address_width_select_q    <= dq_s_w;
                `FVC_OFS_XIP:        execute_in_place_enable_q <= dq_s_w;
                `FVC_OFS_WRAP:       read_wrap_select_q        <= dq_s_w;
                `FVC_OFS_TRAIN:      training_pattern_q        <= dq_s_w;
                `FVC_OFS_INTEGRITY:  integrity_error_control_q <= dq_s_w & `FVC_INTEG_MASK;
                default:             io_protocol_mode_q        <= io_protocol_mode_q;
            endcase
        end
    end

    // Read mux; reserved and unmapped bytes read zero
    always @*
    begin
        case (addr_q)
            `FVC_OFS_IO_MODE:    rd_byte = io_protocol_mode_q;
            `FVC_OFS_DUMMY:      rd_byte = dummy_cycle_count_q;
            `FVC_OFS_DRIVE:      rd_byte = output_drive_select_q;
            `FVC_OFS_ADDR_WIDTH: rd_byte = address_width_select_q;
            `FVC_OFS_XIP:        rd_byte = execute_in_place_enable_q;
            `FVC_OFS_WRAP:       rd_byte = read_wrap_select_q;
            `FVC_OFS_TRAIN:      rd_byte = training_pattern_q;
            `FVC_OFS_INTEGRITY:  rd_byte = integrity_error_control_q;
            default:             rd_byte = 8'h00;
        endcase
    end

    // Link sequencer: command, then address and data, or training straight after the command
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q   <= ST_IDLE;
            is_wr_q   <= 1'b0;
            addr_q    <= 8'h00;
            bit_idx_q <= `FVC_TRAIN_MSB;
            dq_o      <= 8'h00;
            dq_oe_o   <= 1'b0;
            dqs_o     <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!cs_act_w)
            begin
                // Deselect ends the frame at once
                state_q <= ST_IDLE;
                dq_oe_o <= 1'b0;
                dqs_o   <= 1'b0;
            end
            else if (frame_start_w)
            begin
                state_q <= ST_CMD;
                dq_oe_o <= 1'b0;
                dqs_o   <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_CMD:
                    begin
                        if (sck_rise_w)
                        begin
                            is_wr_q   <= (dq_s_w == `FVC_CMD_WRITE);
                            bit_idx_q <= `FVC_TRAIN_MSB;
                            if (dq_s_w == `FVC_CMD_WRITE || dq_s_w == `FVC_CMD_READ)
                                state_q <= ST_ADDR;
                            else if (dq_s_w == `FVC_CMD_TRAIN)
                                state_q <= ST_TRAIN;
                            else
                                state_q <= ST_SKIP;
                        end
                    end
                    ST_ADDR:
                    begin
                        if (sck_rise_w)
                        begin
                            addr_q  <= dq_s_w;
                            state_q <= is_wr_q ? ST_WR : ST_RD;
                        end
                    end
                    ST_WR:
                    begin
                        if (sck_rise_w)
                            addr_q <= addr_q + 8'h01;
                    end
                    ST_RD:
                    begin
                        // New byte on each falling edge, host samples on rising
                        if (sck_fall_w)
                        begin
                            dq_o    <= rd_byte;
                            dq_oe_o <= 1'b1;
                            dqs_o   <= strobe_en_o & ~dqs_o;
                            addr_q  <= addr_q + 8'h01;
                        end
                    end
                    ST_TRAIN:
                    begin
                        // All lines carry the pattern bit; line 3 optionally flipped
                        if (sck_fall_w)
                        begin
                            dq_o      <= {8{training_pattern_q[bit_idx_q]}} ^
                                         (switching_pattern_select ? 8'h00 : `FVC_SSO_MASK);
                            dq_oe_o   <= 1'b1;
                            dqs_o     <= strobe_en_o & ~dqs_o;
                            bit_idx_q <= bit_idx_q - 3'h1;
                        end
                    end
                    ST_SKIP:
                    begin
                        state_q <= ST_SKIP;
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Error indication and first-failure capture; an event beats the frame-start clear
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            err_flag_q       <= 1'b0;
            err_n_o          <= 1'b1;
            ecc_fail_chunk_o <= {CHUNK_W{1'b0}};
            ecc_fail_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sel_event)
                err_flag_q <= 1'b1;
            else if (frame_start_w)
                err_flag_q <= 1'b0;
            err_n_o <= ~((err_flag_q | sel_event) & ~error_pin_enable_n);
            if (sel_event && !ecc_fail_valid_o)
            begin
                ecc_fail_chunk_o <= ecc_chunk_i;
                ecc_fail_valid_o <= 1'b1;
            end
        end
    end

    // Settings decode, registered so every output is a flop
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            octal_ddr_o       <= 1'b0;
            strobe_en_o       <= 1'b1;
            dummy_cycles_o    <= 5'h00;
            dummy_default_o   <= 1'b1;
            drive_sel_o       <= `FVC_SEL_0;
            addr_4byte_o      <= 1'b0;
            xip_enable_o      <= 1'b0;
            wrap_sel_o        <= `FVC_SEL_0;
            crc_chunk_bytes_o <= `FVC_CRC_16;
            crc_parity_en_o   <= 1'b0;
            ecc_enable_o      <= 1'b0;
        end
        else if (ce_i)
        begin
            // Octal-boot parts ignore the mode byte; unlisted codes act as default
            if (strap_q)
            begin
                octal_ddr_o <= 1'b1;
                strobe_en_o <= 1'b1;
            end
            else
            begin
                octal_ddr_o <= (io_protocol_mode_q == `FVC_IOM_ODDR_DQS) |
                               (io_protocol_mode_q == `FVC_IOM_ODDR_NODQS);
                strobe_en_o <= (io_protocol_mode_q != `FVC_IOM_XSPI_NODQS) &
                               (io_protocol_mode_q != `FVC_IOM_ODDR_NODQS);
            end

            // 00h and 1Fh (and reserved codes) fall back to per-command default
            if (dummy_cycle_count_q != `FVC_DUMMY_ZERO && dummy_cycle_count_q <= `FVC_DUMMY_MAX)
            begin
                dummy_cycles_o  <= dummy_cycle_count_q[4:0];
                dummy_default_o <= 1'b0;
            end
            else
            begin
                dummy_cycles_o  <= 5'h00;
                dummy_default_o <= 1'b1;
            end

            case (output_drive_select_q)
                `FVC_CODE_FE: drive_sel_o <= `FVC_SEL_1;
                `FVC_CODE_FD: drive_sel_o <= `FVC_SEL_2;
                `FVC_CODE_FC: drive_sel_o <= `FVC_SEL_3;
                default:      drive_sel_o <= `FVC_SEL_0;
            endcase

            case (read_wrap_select_q)
                `FVC_CODE_FE: wrap_sel_o <= `FVC_SEL_1;
                `FVC_CODE_FD: wrap_sel_o <= `FVC_SEL_2;
                `FVC_CODE_FC: wrap_sel_o <= `FVC_SEL_3;
                default:      wrap_sel_o <= `FVC_SEL_0;
            endcase

            addr_4byte_o <= (address_width_select_q == `FVC_CODE_FE);
            // Only enables; entering XIP is the host's confirmation on a read
            xip_enable_o <= (execute_in_place_enable_q == `FVC_CODE_FE);

            case (crc_chunk_size)
                `FVC_CRC_CODE_16: crc_chunk_bytes_o <= `FVC_CRC_16;
                `FVC_CRC_CODE_32: crc_chunk_bytes_o <= `FVC_CRC_32;
                `FVC_CRC_CODE_64: crc_chunk_bytes_o <= `FVC_CRC_64;
                default:          crc_chunk_bytes_o <= `FVC_CRC_128;
            endcase

            crc_parity_en_o <= ~crc_parity_enable_n &
                               (strap_q |
                                (io_protocol_mode_q == `FVC_IOM_ODDR_DQS) |
                                (io_protocol_mode_q == `FVC_IOM_ODDR_NODQS));
            ecc_enable_o    <= ecc_on;
        end
    end
endmodule // fvc_bank

/* File: rtl/fvc_consts.vh */
`ifndef FVC_CONSTS_VH
`define FVC_CONSTS_VH

// Byte offsets within the bank
`define FVC_OFS_IO_MODE      8'h00
`define FVC_OFS_DUMMY        8'h01
`define FVC_OFS_DRIVE        8'h03
`define FVC_OFS_ADDR_WIDTH   8'h05
`define FVC_OFS_XIP          8'h06
`define FVC_OFS_WRAP         8'h07
`define FVC_OFS_TRAIN        8'h0A
`define FVC_OFS_INTEGRITY    8'h0B

// Reset values
`define FVC_RST_IO_MODE      8'hFF
`define FVC_RST_DUMMY        8'h1F
`define FVC_RST_DRIVE        8'hFF
`define FVC_RST_ADDR_WIDTH   8'hFF
`define FVC_RST_XIP          8'hFF
`define FVC_RST_WRAP         8'hFF
`define FVC_RST_TRAIN        8'h55
`define FVC_RST_INTEGRITY    8'h7F

// Integrity byte field positions
`define FVC_B_SSO            6
`define FVC_B_CRCSZ_HI       5
`define FVC_B_CRCSZ_LO       4
`define FVC_B_CRC_EN_N       3
`define FVC_B_ERR_TYPE       2
`define FVC_B_ERR_PIN_EN_N   1
`define FVC_B_ECC_EN_N       0
`define FVC_INTEG_MASK       8'h7F

// I/O protocol mode codes
`define FVC_IOM_XSPI_DQS     8'hFF
`define FVC_IOM_XSPI_NODQS   8'hDF
`define FVC_IOM_ODDR_DQS     8'hE7
`define FVC_IOM_ODDR_NODQS   8'hC7

// Generic one-of-four selector codes
`define FVC_CODE_FF          8'hFF
`define FVC_CODE_FE          8'hFE
`define FVC_CODE_FD          8'hFD
`define FVC_CODE_FC          8'hFC

// Two-bit selector outputs
`define FVC_SEL_0            2'h0
`define FVC_SEL_1            2'h1
`define FVC_SEL_2            2'h2
`define FVC_SEL_3            2'h3

// Dummy cycle codes
`define FVC_DUMMY_ZERO       8'h00
`define FVC_DUMMY_MAX        8'h1E
`define FVC_DUMMY_DEF        8'h1F

// CRC chunk sizes in bytes
`define FVC_CRC_CODE_16      2'h3
`define FVC_CRC_CODE_32      2'h2
`define FVC_CRC_CODE_64      2'h1
`define FVC_CRC_16           8'h10
`define FVC_CRC_32           8'h20
`define FVC_CRC_64           8'h40
`define FVC_CRC_128          8'h80

// Link commands and training constants
`define FVC_CMD_WRITE        8'h81
`define FVC_CMD_READ         8'h85
`define FVC_CMD_TRAIN        8'h5A
`define FVC_SSO_MASK         8'h08
`define FVC_TRAIN_MSB        3'h7

`endif

/* File: rtl/fvc_link_sync.v */
// Link pin synchroniser and edge finder
module fvc_link_sync (
    // Clock, reset, enable
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       ce_i,
    // Raw pins
    input  wire       sck_i,
    input  wire       cs_n_i,
    input  wire [7:0] dq_i,
    input  wire       strap_i,
    // Synchronised view
    output reg        sck_rise_o,
    output reg        sck_fall_o,
    output wire       cs_act_o,
    output reg        frame_start_o,
    output wire [7:0] dq_o,
    output wire       strap_o
);
    localparam        NB      = 11;
    localparam [10:0] RST_VEC = 11'h100;   // Chip select idles high

    wire [NB-1:0] raw_w;
    wire [NB-1:0] s2_w;
    reg           sck_prev_q;
    reg           cs_prev_q;

    assign raw_w = {strap_i, sck_i, cs_n_i, dq_i};

    // Two-flop chain per pin; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            always @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    s1_q <= RST_VEC[g];
                    s2_q <= RST_VEC[g];
                end
                else if (ce_i)
                begin
                    s1_q <= raw_w[g];
                    s2_q <= s1_q;
                end
            end
            assign s2_w[g] = s2_q;
        end
    endgenerate

    assign dq_o     = s2_w[7:0];
    assign cs_act_o = ~s2_w[8];
    assign strap_o  = s2_w[10];

    // Edges are taken from the settled stage only
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sck_prev_q    <= 1'b0;
            cs_prev_q     <= 1'b0;
            sck_rise_o    <= 1'b0;
            sck_fall_o    <= 1'b0;
            frame_start_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sck_prev_q    <= s2_w[9];
            cs_prev_q     <= ~s2_w[8];
            sck_rise_o    <= s2_w[9] & ~sck_prev_q;
            sck_fall_o    <= ~s2_w[9] & sck_prev_q;
            frame_start_o <= ~s2_w[8] & ~cs_prev_q;
        end
    end
endmodule // fvc_link_sync

/* File: tb/fvc_bank_monitor.sv */
// Checks on ECC capture, error pin and decode
module fvc_bank_monitor #(
    parameter CHUNK_W = 28
) (
    // Clock, reset, frame select
    input logic               clk_i,
    input logic               rstn_i,
    input logic               cs_n_i,
    // ECC events and results
    input logic               ecc_corr_i,
    input logic               ecc_det_i,
    input logic [CHUNK_W-1:0] ecc_chunk_i,
    input logic               err_n_o,
    input logic [CHUNK_W-1:0] ecc_fail_chunk_o,
    input logic               ecc_fail_valid_o,
    // Decoded settings
    input logic               octal_ddr_o,
    input logic [4:0]         dummy_cycles_o,
    input logic               dummy_default_o,
    input logic [7:0]         crc_chunk_bytes_o,
    input logic               crc_parity_en_o,
    input logic               ecc_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Event offered while correction stays off on both cycles
    sequence s_evt_off;
        (ecc_corr_i || ecc_det_i) && !ecc_enable_o ##1 !ecc_enable_o;
    endsequence

    // Error pin low through a quiet link, no frame start pending
    sequence s_err_quiet;
        (!err_n_o && cs_n_i) [*4];
    endsequence

    a_ecc_off_ignore: assert property (s_evt_off |-> !$rose(ecc_fail_valid_o) && !$fell(err_n_o))
        else $error("event taken while correction off");
    a_fail_capture: assert property ($rose(ecc_fail_valid_o) |->
        $past(ecc_corr_i || ecc_det_i) && ecc_fail_chunk_o == $past(ecc_chunk_i))
        else $error("failure chunk not taken from the event");
    a_fail_hold: assert property (ecc_fail_valid_o |=> ecc_fail_valid_o && $stable(ecc_fail_chunk_o))
        else $error("failure chunk changed after first capture");
    a_err_cause: assert property ($fell(err_n_o) |-> $past(ecc_corr_i || ecc_det_i))
        else $error("error pin fell without an event");
    a_err_needs_ecc: assert property (!err_n_o |-> ecc_enable_o)
        else $error("error pin low with correction off");
    a_err_holds: assert property (s_err_quiet |=> !err_n_o)
        else $error("error pin released without a frame");
    a_crc_size: assert property (crc_chunk_bytes_o inside {8'h10, 8'h20, 8'h40, 8'h80})
        else $error("chunk size outside 16..128");
    a_parity_octal: assert property (crc_parity_en_o |-> octal_ddr_o)
        else $error("parity on outside octal mode");
    a_dummy_range: assert property (!dummy_default_o |-> dummy_cycles_o inside {[1:30]})
        else $error("explicit dummy count out of range");
endmodule // fvc_bank_monitor

/* File: tb/fvc_host_model.sv */
`include "fvc_consts.vh"

// Link master standing in for the flash controller
module fvc_host_model (
    // Link pins towards the bank
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [7:0] dq_o,
    // Data back from the bank
    input  logic [7:0] dq_i
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle link: clock parked low, deselected
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        dq_o = 8'h00;
    end

    // Odd offset keeps link edges off clock edges
    task automatic start(input logic [7:0] cmd);
        #3 cs_n_o = 1'b0;
        #80;
        put(cmd);
    endtask

    // Byte set up and held around the rising edge
    task automatic put(input logic [7:0] v);
        dq_o = v;
        #40 sck_o = 1'b1;
        #80 sck_o = 1'b0;
        #40;
    endtask

    // Toggle lines so stale data never matches
    task automatic get(output logic [7:0] v);
        dq_o = ~dq_o;
        #40 sck_o = 1'b1;
        v = dq_i;
        #80 sck_o = 1'b0;
        #40;
    endtask

    // Gap far above the four-clock minimum
    task automatic stop;
        cs_n_o = 1'b1;
        dq_o = ~dq_o;
        #160;
    endtask

    // Single byte write; callers send documented codes only
    task automatic wr(input logic [7:0] a, d);
        start(`FVC_CMD_WRITE);
        put(a);
        put(d);
        stop;
    endtask
endmodule // fvc_host_model

/* File: tb/fvc_bank_test.sv */
`include "fvc_consts.vh"

module fvc_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rstn_i, ce_i, boot_octal_i, ecc_corr_i, ecc_det_i, sck_i, cs_n_i;
    logic        dq_oe_o, dqs_o, err_n_o, ecc_fail_valid_o, octal_ddr_o, strobe_en_o;
    logic        dummy_default_o, addr_4byte_o, xip_enable_o, crc_parity_en_o, ecc_enable_o;
    logic [7:0]  dq_i, dq_o, crc_chunk_bytes_o, b;
    logic [27:0] ecc_chunk_i, ecc_fail_chunk_o;
    logic [4:0]  dummy_cycles_o;
    logic [1:0]  drive_sel_o, wrap_sel_o;
    int          n_fail = 0, compares = 0, cyc = 0;

    fvc_bank #(.CHUNK_W(28)) DUT (.*);
    fvc_host_model u_h (.sck_o(sck_i), .cs_n_o(cs_n_i), .dq_o(dq_i), .dq_i(dq_o));

    // System clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done;
        end
    end

    task chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Strap stable before release
    task rst(input logic s);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        boot_octal_i <= s;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask

    task pulse(input logic det, input logic [27:0] a);
        @(posedge clk_i);
        ecc_det_i <= det;
        ecc_corr_i <= ~det;
        ecc_chunk_i <= a;
        @(posedge clk_i);
        ecc_det_i <= 1'b0;
        ecc_corr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // Whole bank in one burst, reserved bytes included
    task t_defaults;
        logic [7:0] e [12] = '{8'hFF, 8'h1F, 0, 8'hFF, 0, 8'hFF, 8'hFF, 8'hFF, 0, 0, 8'h55, 8'h7F};
        chk({strobe_en_o, dummy_default_o, octal_ddr_o, ecc_enable_o, err_n_o}, 5'h19);
        u_h.start(`FVC_CMD_READ);
        u_h.put(8'h00);
        for (int i = 0; i < 12; i++)
        begin
            u_h.get(b);
            chk(b, e[i]);
            chk({dq_oe_o, dqs_o}, {1'b1, i[0]});
        end
        u_h.stop;
    endtask

    // Four modes, then octal-boot part
    task t_modes;
        logic [7:0] m [4] = '{8'hFF, 8'hDF, 8'hE7, 8'hC7};
        for (int i = 0; i < 4; i++)
        begin
            u_h.wr(8'h00, m[i]);
            chk({octal_ddr_o, strobe_en_o}, {i[1], ~i[0]});
        end
        rst(1'b1);
        u_h.wr(8'h00, 8'hDF);
        chk({octal_ddr_o, strobe_en_o}, 2'b11);
        rst(1'b0);
    endtask

    task t_sel;
        for (int i = 0; i < 4; i++)
        begin
            u_h.wr(8'h03, ~i[7:0]);
            u_h.wr(8'h07, ~i[7:0]);
            chk(drive_sel_o, i);
            chk(wrap_sel_o, i);
            if (i < 2)
            begin
                u_h.wr(8'h05, ~i[7:0]);
                u_h.wr(8'h06, ~i[7:0]);
                chk(addr_4byte_o, i);
                chk(xip_enable_o, i);
            end
        end
    endtask

    // Range ends, then both default codes
    task t_dummy;
        logic [7:0] c [4] = '{8'h01, 8'h1E, 8'h00, 8'h1F};
        for (int i = 0; i < 4; i++)
        begin
            u_h.wr(8'h01, c[i]);
            chk(dummy_default_o, i > 1);
            if (i < 2)
                chk(dummy_cycles_o, c[i]);
        end
    endtask

    task t_integ;
        u_h.wr(8'h00, 8'hE7);
        for (int i = 0; i < 4; i++)
        begin
            u_h.wr(8'h0B, {2'b01, ~i[1:0], 3'b011, i[0]});
            chk(crc_chunk_bytes_o, 8'h10 << i);
            chk(ecc_enable_o, !i[0]);
            chk(crc_parity_en_o, 1);
        end
        u_h.wr(8'h00, 8'hFF);
        chk(crc_parity_en_o, 0);
    endtask

    task t_ecc;
        pulse(1'b1, 28'h1234567);
        chk({ecc_fail_valid_o, err_n_o}, 2'b01);
        u_h.wr(8'h0B, 8'h7C);
        pulse(1'b0, 28'h1234567);
        chk({ecc_fail_valid_o, err_n_o}, 2'b01);
        pulse(1'b1, 28'hABCDEF0);
        pulse(1'b1, 28'h0F0F0F0);
        chk({ecc_fail_valid_o, err_n_o}, 2'b10);
        chk(ecc_fail_chunk_o, 28'hABCDEF0);
        u_h.wr(8'h0B, 8'h78);
        pulse(1'b1, 28'h0F0F0F0);
        chk(err_n_o, 1);
        pulse(1'b0, 28'h0F0F0F0);
        chk(err_n_o, 0);
        u_h.wr(8'h0B, 8'h7A);
        pulse(1'b0, 28'h0F0F0F0);
        chk(err_n_o, 1);
    endtask

    // Default pattern, then written one with line 3 flipped
    task t_train;
        logic [7:0] p;
        for (int s = 0; s < 2; s++)
        begin
            if (s)
            begin
                u_h.wr(8'h0A, 8'hA3);
                u_h.wr(8'h0B, 8'h3A);
            end
            p = s ? 8'hA3 : 8'h55;
            u_h.start(`FVC_CMD_TRAIN);
            for (int k = 7; k >= 0; k--)
            begin
                u_h.get(b);
                chk(b, {8{p[k]}} ^ (s ? 8'h08 : 8'h00));
            end
            u_h.stop;
        end
    endtask

    initial
    begin
        rstn_i = 1'b0;
        ce_i = 1'b1;
        boot_octal_i = 1'b0;
        ecc_corr_i = 1'b0;
        ecc_det_i = 1'b0;
        ecc_chunk_i = 28'h0;
        rst(1'b0);
        t_defaults;
        t_modes;
        t_sel;
        t_dummy;
        t_integ;
        t_ecc;
        t_train;
        test_done;
    end
endmodule // fvc_bank_test

bind fvc_bank fvc_bank_monitor #(.CHUNK_W(CHUNK_W)) u_mon (.*);
